// >>> verilog/ldc_cfg.svh
// register offsets, field positions and reset values of the ladder control block
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
`define LDC_ADDR_W          4
`define LDC_OFF_CTRL0       4'h0
`define LDC_OFF_LEVEL       4'h1
`define LDC_OFF_STATUS      4'h2
`define LDC_CTRL0_RESET     8'h00
`define LDC_LEVEL_RESET     8'h00
`define LDC_BIT_ENABLE      7
`define LDC_BIT_PIN1_OE     5
`define LDC_BIT_PIN2_OE     4
`define LDC_PSS_HI          3
`define LDC_PSS_LO          2
`define LDC_CODE_HI         4
`define LDC_CODE_LO         0
`define LDC_CTRL0_MASK      8'hbc
`define LDC_LEVEL_MASK      8'h1f
`endif

// >>> verilog/ldc_pkg.sv
// types shared by the ladder control block
package ldc_pkg;
    typedef enum logic [1:0] {
        LDC_SRC_SUPPLY,
        LDC_SRC_EXT_PIN,
        LDC_SRC_FIXED_REF,
        LDC_SRC_RESERVED
    } ldc_src_e;
    typedef logic [4:0] ldc_code_t;
endpackage

// >>> verilog/ldc_ladder_dac_control.sv
// control registers and analog steering of the 5-bit reference ladder
`timescale 1ns/1ps
`include "ldc_cfg.svh"

// How it works
// - bit 7 of control zero turns ladder on
// - five-bit level code gives 32 levels
// - level = bottom + span times code over 32
// - bits 5 and 4 route level to pins
// - routed pin loses digital driver and input
// - port read of routed pin returns zero
// - source field picks supply, pin, fixed reference
// - sleep wake keeps control zero unchanged
// - reset clears enable, pin routing, level code
// - unimplemented register bits read as zero
// - level also feeds comparator and ADC
module ldc_ladder_dac_control
    import ldc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // register port
    input  wire logic [`LDC_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    // sleep status, only observed
    input  wire logic                   wake_i,
    // digital side of the two output pins
    input  wire logic                   pin_one_in_i,
    input  wire logic                   pin_two_in_i,
    input  wire logic                   pin_one_drive_i,
    input  wire logic                   pin_two_drive_i,
    output logic                        pin_one_read_o,
    output logic                        pin_two_read_o,
    output logic                        pin_one_digital_off_o,
    output logic                        pin_two_digital_off_o,
    output logic                        pin_one_drive_o,
    output logic                        pin_two_drive_o,
    // analog switch controls
    output logic                        ladder_on_o,
    output logic [4:0]                  level_code_o,
    output logic                        top_supply_o,
    output logic                        top_ext_pin_o,
    output logic                        top_fixed_ref_o,
    output logic                        bottom_ground_o,
    output logic                        analog_out_pin_one_o,
    output logic                        analog_out_pin_two_o,
    output logic                        comparator_feed_o,
    output logic                        adc_feed_o
);

    logic       ladder_enable;
    logic       pin_one_output_enable;
    logic       pin_two_output_enable;
    ldc_src_e   positive_source_select;
    ldc_code_t  level_code;
    logic [7:0] ctrl0_view;
    logic [7:0] level_view;
    logic [7:0] next_rdata;
    logic [1:0] pin_routed;
    logic [1:0] pin_level_in;
    logic [1:0] pin_drive_req;
    logic [1:0] pin_off_q;
    logic [1:0] pin_drive_q;
    logic [1:0] pin_read_q;

    // control zero; wake does not touch it, only register writes and device reset do
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ladder_enable          <= 1'b0;
            pin_one_output_enable  <= 1'b0;
            pin_two_output_enable  <= 1'b0;
            positive_source_select <= LDC_SRC_SUPPLY;
        end
        else if (wr_i && addr_i == `LDC_OFF_CTRL0)
        begin
            ladder_enable          <= wdata_i[`LDC_BIT_ENABLE];
            pin_one_output_enable  <= wdata_i[`LDC_BIT_PIN1_OE];
            pin_two_output_enable  <= wdata_i[`LDC_BIT_PIN2_OE];
            positive_source_select <= ldc_src_e'(wdata_i[`LDC_PSS_HI:`LDC_PSS_LO]);
        end
    end

    // level code register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            level_code <= 5'h00;
        else if (wr_i && addr_i == `LDC_OFF_LEVEL)
            level_code <= wdata_i[`LDC_CODE_HI:`LDC_CODE_LO];
    end

    // read views with unimplemented bits forced low
    always_comb
    begin
        ctrl0_view = {ladder_enable, 1'b0, pin_one_output_enable, pin_two_output_enable,
                      positive_source_select, 2'b00} & `LDC_CTRL0_MASK;
        level_view = {3'b000, level_code} & `LDC_LEVEL_MASK;
        next_rdata = 8'h00;
        if (rd_i)
        begin
            unique case (addr_i)
                `LDC_OFF_CTRL0:  next_rdata = ctrl0_view;
                `LDC_OFF_LEVEL:  next_rdata = level_view;
                `LDC_OFF_STATUS: next_rdata = {7'h00, wake_i};
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= next_rdata;
    end

    // ladder switches: top source, bottom ground, code taps
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ladder_on_o     <= 1'b0;
            level_code_o    <= 5'h00;
            top_supply_o    <= 1'b0;
            top_ext_pin_o   <= 1'b0;
            top_fixed_ref_o <= 1'b0;
            bottom_ground_o <= 1'b0;
        end
        else
        begin
            ladder_on_o     <= ladder_enable;
            level_code_o    <= level_code;
            top_supply_o    <= ladder_enable && positive_source_select == LDC_SRC_SUPPLY;
            top_ext_pin_o   <= ladder_enable && positive_source_select == LDC_SRC_EXT_PIN;
            top_fixed_ref_o <= ladder_enable && positive_source_select == LDC_SRC_FIXED_REF;
            bottom_ground_o <= ladder_enable;
        end
    end

    // analog routing to pins and internal consumers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            analog_out_pin_one_o <= 1'b0;
            analog_out_pin_two_o <= 1'b0;
            comparator_feed_o    <= 1'b0;
            adc_feed_o           <= 1'b0;
        end
        else
        begin
            analog_out_pin_one_o <= pin_one_output_enable;
            analog_out_pin_two_o <= pin_two_output_enable;
            comparator_feed_o    <= ladder_enable;
            adc_feed_o           <= ladder_enable;
        end
    end

    // gather the two pins so one loop serves both; index 0 is pin one
    assign pin_routed    = {pin_two_output_enable, pin_one_output_enable};
    assign pin_level_in  = {pin_two_in_i, pin_one_in_i};
    assign pin_drive_req = {pin_two_drive_i, pin_one_drive_i};

    // digital override of routed pins, one flop set per pin
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                pin_off_q[p]   <= 1'b0;
                pin_drive_q[p] <= 1'b0;
                pin_read_q[p]  <= 1'b0;
            end
            else
            begin
                pin_off_q[p]   <= pin_routed[p];
                pin_drive_q[p] <= pin_drive_req[p] && !pin_routed[p];
                pin_read_q[p]  <= pin_level_in[p] && !pin_routed[p];
            end
        end
    end

    // pin outputs taken straight from the per-pin flops
    assign pin_one_digital_off_o = pin_off_q[0];
    assign pin_two_digital_off_o = pin_off_q[1];
    assign pin_one_drive_o       = pin_drive_q[0];
    assign pin_two_drive_o       = pin_drive_q[1];
    assign pin_one_read_o        = pin_read_q[0];
    assign pin_two_read_o        = pin_read_q[1];

endmodule

// >>> tb/ldc_props.sv
// assertions on the ladder control block ports
`timescale 1ns/1ps
module ldc_props (
    input wire logic       clk_i, rst_n_i, wr_i, rd_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i, rdata_o,
    input wire logic [4:0] level_code_o,
    input wire logic       ladder_on_o, top_supply_o, top_ext_pin_o, top_fixed_ref_o,
    input wire logic       bottom_ground_o, comparator_feed_o, adc_feed_o, pin_one_read_o,
    input wire logic       pin_two_drive_o, pin_two_digital_off_o, analog_out_pin_one_o,
    input wire logic       analog_out_pin_two_o
);
    // one clock domain
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // write effects appear two edges after the write
    property p_en; wr_i && addr_i == 4'h0 |-> ##2 ladder_on_o == $past(wdata_i[7], 2); endproperty
    a_en: assert property (p_en) else $error("enable mismatch");
    property p_code; wr_i && addr_i == 4'h1 |-> ##2 level_code_o == $past(wdata_i[4:0], 2);
    endproperty
    a_code: assert property (p_code) else $error("level code mismatch");
    property p_pin; wr_i && addr_i == 4'h0 |-> ##2
        {analog_out_pin_one_o, analog_out_pin_two_o} == $past(wdata_i[5:4], 2); endproperty
    a_pin: assert property (p_pin) else $error("pin routing mismatch");
    property p_src; wr_i && addr_i == 4'h0 && wdata_i[7] |-> ##2
        {top_supply_o, top_ext_pin_o, top_fixed_ref_o} == (3'b100 >> $past(wdata_i[3:2], 2));
    endproperty
    a_src: assert property (p_src) else $error("top source mismatch");
    // switches follow the enable
    property p_gnd; bottom_ground_o == ladder_on_o; endproperty
    a_gnd: assert property (p_gnd) else $error("bottom ground mismatch");
    property p_feed; comparator_feed_o == ladder_on_o && adc_feed_o == ladder_on_o; endproperty
    a_feed: assert property (p_feed) else $error("internal feed mismatch");
    // routed pins lose digital function; unimplemented control bits read zero
    property p_rd0; analog_out_pin_one_o |-> !pin_one_read_o; endproperty
    a_rd0: assert property (p_rd0) else $error("routed pin read not zero");
    property p_drv; analog_out_pin_two_o |-> !pin_two_drive_o && pin_two_digital_off_o;
    endproperty
    a_drv: assert property (p_drv) else $error("routed pin still digital");
    property p_unimp; rd_i && addr_i == 4'h0 |=> (rdata_o & 8'h43) == 8'h00; endproperty
    a_unimp: assert property (p_unimp) else $error("unimplemented bits set");
endmodule

bind ldc_ladder_dac_control ldc_props u_props (.*);

// >>> tb/ladder_dac_control_tb.sv
// self-checking bench of the ladder control block
`timescale 1ns/1ps
module ladder_dac_control_tb;
    typedef struct {logic [7:0] c; logic [7:0] l; logic [2:0] t;} ldc_row_s;
    logic clk_i, rst_n_i, wr_i, rd_i, wake_i, pin_one_in_i, pin_two_in_i;
    logic pin_one_drive_i, pin_two_drive_i, pin_one_read_o, pin_two_read_o;
    logic pin_one_digital_off_o, pin_two_digital_off_o, pin_one_drive_o, pin_two_drive_o;
    logic ladder_on_o, top_supply_o, top_ext_pin_o, top_fixed_ref_o, bottom_ground_o;
    logic analog_out_pin_one_o, analog_out_pin_two_o, comparator_feed_o, adc_feed_o;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [4:0]  level_code_o;
    logic [19:0] got;
    int          err_count, num_checks;
    ldc_row_s    rows [5] = '{'{8'h80, 8'h00, 3'b100}, '{8'ha4, 8'h1f, 3'b010},
        '{8'h98, 8'h10, 3'b001}, '{8'hfc, 8'hff, 3'b000}, '{8'h3f, 8'h01, 3'b000}};

    ldc_ladder_dac_control DUT (.*);

    // all outputs except rdata_o in one vector
    assign got = {ladder_on_o, analog_out_pin_one_o, analog_out_pin_two_o, top_supply_o,
        top_ext_pin_o, top_fixed_ref_o, bottom_ground_o, comparator_feed_o, adc_feed_o,
        level_code_o, pin_one_read_o, pin_two_read_o, pin_one_drive_o, pin_two_drive_o,
        pin_one_digital_off_o, pin_two_digital_off_o};

    function automatic logic [19:0] expv(logic [7:0] c, logic [7:0] l, logic [2:0] t);
        return {c[7], c[5], c[4], t, c[7], c[7], c[7], l[4:0], ~c[5], ~c[4], ~c[5], ~c[4],
            c[5], c[4]};
    endfunction

    task automatic bus(input logic w, r, input logic [3:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [19:0] g, e);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        #1 chk({12'h0, rdata_o}, {12'h0, e});
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // table rows, then wake and reset cases
    initial
    begin
        {rst_n_i, wr_i, rd_i, wake_i, addr_i, wdata_i} = '0;
        {pin_one_in_i, pin_two_in_i, pin_one_drive_i, pin_two_drive_i} = 4'hf;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            bus(1'b1, 1'b0, 4'h0, rows[i].c);
            bus(1'b1, 1'b0, 4'h1, rows[i].l);
            repeat (2) bus(1'b0, 1'b0, 4'h0, 8'h00);
            #1 chk(got, expv(rows[i].c, rows[i].l, rows[i].t));
            rdc(4'h0, rows[i].c & 8'hbc);
            rdc(4'h1, rows[i].l & 8'h1f);
            rdc(4'h3, 8'h00);
        end
        bus(1'b1, 1'b0, 4'h1, 8'h15);
        rdc(4'h1, 8'h15);
        wake_i <= 1'b1; // last row left the ladder disabled before sleep
        repeat (3) bus(1'b0, 1'b0, 4'h0, 8'h00);
        rdc(4'h0, 8'h3c);
        rdc(4'h2, 8'h01);
        rst_n_i = 1'b0;
        #1 chk(got, 20'h0);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc(4'h0, 8'h00);
        rdc(4'h1, 8'h00);
        complete_run();
    end
endmodule
